/* hdl/fnd_device.sv */
// Notes on behaviour
// - Compare rate: reference times doubler over divider
// - Divide value is integer plus fraction over modulus
// - Modulus accepted from 13 up to 4095
// - Host keeps modulus at least 50 with dither
// - Third-order modulator steps once per compare cycle
// - Undithered repeat length follows modulus divisibility
// - Dithered sequence repeats after two to twenty-one
// - Host first sets power-down, then grounds pump
// - Host waits ten milliseconds after first two
// - Host clears test, initialises modes, longer threshold
// - Host writes three timer words
// - Host writes phase, config, then frequency word
// - Host releases pump, clears power-down, rewrites frequency
// - Power-up after power-down clear; lock after frequency
// - Low three bits select destination register
// - New divide values load on next compare cycle
// - Phase and config shadowed until frequency latch
`timescale 1ns/1ps
`default_nettype none
`include "fnd_defines.svh"
module fnd_device
  import fnd_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  fnd_link_if.device link,
  output logic power_down,
  output logic pump_grounded,
  output logic dither_on,
  output logic compare_pulse,
  output logic [8:0] divide_value,
  output logic divide_valid,
  output logic channel_acquired
);
  fnd_lnk_s l_r, l_nxt;
  fnd_dev_s d_r, d_nxt;
  logic capture;
  logic sdm_load;
  logic pd_now;
  logic signed [3:0] sdm_code;
  fnd_word_t word;
  logic [2:0] sel;
  logic [11:0] mod_eff;
  logic [3:0] rdiv;
  logic [4:0] ref_div;
  logic [5:0] ref_sum;
  logic [9:0] div_sum;

  // Numerator field shared by fraction, modulus and phase words
  function automatic logic [11:0] fnd_num(input fnd_word_t w);
    fnd_num = w[`FND_NUM_HI:`FND_NUM_LO];
  endfunction : fnd_num

  // Power-down bits of a power-down word
  function automatic logic fnd_pd(input logic [7:0] w);
    fnd_pd = |w[`FND_PD_HI:`FND_PD_LO];
  endfunction : fnd_pd

  // Shift register on the link clock; no reset, it only holds data
  always_comb begin
    l_nxt.shift = {l_r.shift[`FND_WORD_W-2:0], link.sdata};
  end

  always_ff @(posedge link.link_clk) begin
    l_r <= l_nxt;
  end

  // Word crosses as a held bus: the link clock is idle while the strobe is high
  assign word = l_r.shift;
  assign sel = word[`FND_SEL_HI:0];
  assign capture = d_r.lat_s & ~d_r.lat_d;
  assign pd_now = fnd_pd(d_r.pd_word);

  // Too small a modulus is raised to the floor rather than stalling the wrap
  assign mod_eff = (fnd_num(d_r.cfg_act) < `FND_MOD_MIN) ? `FND_MOD_MIN : fnd_num(d_r.cfg_act);
  assign dither_on = (d_r.mode_word[`FND_MODE_HI:`FND_MODE_LO] == `FND_MODE_DITHER);

  // Reference divider in half steps so the doubler needs no second clock
  assign rdiv = d_r.cfg_act[`FND_RDIV_HI:`FND_RDIV_LO];
  always_comb begin
    logic [3:0] r1;
    r1 = (rdiv == 4'h0) ? 4'h1 : rdiv;
    ref_div = d_r.cfg_act[`FND_HALF_BIT] ? {r1, 1'h0} : {1'h0, r1};
    ref_sum = d_r.ref_acc + (d_r.cfg_act[`FND_DBL_BIT] ? 6'h02 : 6'h01);
  end

  // Seed the modulator only on the first compare cycle after a frequency latch
  assign sdm_load = d_r.cmp_tick & d_r.load_pend;

  // Integer part plus signed modulator code
  assign div_sum = {2'h0, d_r.freq_word[`FND_INT_HI:`FND_INT_LO]} + {{6{sdm_code[3]}}, sdm_code};

  fnd_sdm u_sdm (
    .aclk(aclk),
    .aresetn(aresetn),
    .step(d_r.cmp_tick),
    .load(sdm_load),
    .dither_en(dither_on),
    .fraction_numerator(fnd_num(d_r.freq_word)),
    .fraction_modulus(mod_eff),
    .phase_seed(fnd_num(d_r.phase_act)),
    .code(sdm_code)
  );

  // Register file, compare timing, divide word and diagnostic pin
  always_comb begin
    d_nxt = d_r;
    // Strobe from the other party passes two flops before use
    d_nxt.lat_m = link.word_latch_strobe;
    d_nxt.lat_s = d_r.lat_m;
    d_nxt.lat_d = d_r.lat_s;

    // Pending load is consumed on its compare cycle; a new latch re-arms it below
    if (sdm_load) begin
      d_nxt.load_pend = 1'h0;
    end

    if (capture) begin
      case (sel)
        `FND_SEL_FREQ: begin
          d_nxt.freq_word = word;
          d_nxt.cfg_act = d_r.cfg_sh;
          d_nxt.phase_act = d_r.phase_sh;
          d_nxt.load_pend = 1'h1;
          d_nxt.chan_ok = ~pd_now;
        end
        `FND_SEL_CONFIG: begin
          d_nxt.cfg_sh = word;
        end
        `FND_SEL_PHASE: begin
          d_nxt.phase_sh = word;
        end
        `FND_SEL_FUNC: begin
          d_nxt.func_word = word[15:0];
        end
        `FND_SEL_PDOWN: begin
          d_nxt.pd_word = word[7:0];
        end
        `FND_SEL_MODE: begin
          d_nxt.mode_word = word[15:0];
        end
        default: begin
          // Timer and test words steer analog sections only
        end
      endcase
    end

    // Setting power-down drops the acquired channel
    if (fnd_pd(d_nxt.pd_word)) begin
      d_nxt.chan_ok = 1'h0;
    end

    // Reference counter sits at its load state while powered down
    d_nxt.cmp_tick = 1'h0;
    if (pd_now) begin
      d_nxt.ref_acc = 6'h00;
    end else if (ref_sum >= {1'h0, ref_div}) begin
      d_nxt.cmp_tick = 1'h1;
      // At most one compare pulse per reference cycle; excess is capped
      if ((ref_sum - {1'h0, ref_div}) < {1'h0, ref_div}) begin
        d_nxt.ref_acc = ref_sum - {1'h0, ref_div};
      end else begin
        d_nxt.ref_acc = {1'h0, ref_div} - 6'h01;
      end
    end else begin
      d_nxt.ref_acc = ref_sum;
    end

    // Divide word follows the modulator output by one cycle
    d_nxt.step_d = d_r.cmp_tick;
    d_nxt.div_valid = d_r.step_d;
    if (d_r.step_d) begin
      d_nxt.div_value = div_sum[8:0];
    end

    // Diagnostic multiplexer
    d_nxt.diag_oe = 1'h1;
    d_nxt.diag_o = 1'h0;
    case (d_r.mode_word[`FND_MUX_HI:`FND_MUX_LO])
      `FND_MUX_OFF: begin
        d_nxt.diag_oe = 1'h0;
      end
      `FND_MUX_LOCK: begin
        d_nxt.diag_o = d_r.chan_ok;
      end
      `FND_MUX_NDIV: begin
        d_nxt.diag_o = d_r.step_d;
      end
      `FND_MUX_HIGH: begin
        d_nxt.diag_o = 1'h1;
      end
      `FND_MUX_RCNT, `FND_MUX_RDIV: begin
        d_nxt.diag_o = d_r.cmp_tick;
      end
      `FND_MUX_LOW: begin
        d_nxt.diag_o = 1'h0;
      end
      default: begin
        d_nxt.diag_oe = 1'h0;
      end
    endcase
  end

  // Reset stands for power-on: powered down, pump grounded, nothing latched
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      d_r <= '0;
      d_r.pd_word <= `FND_PD_RST;
    end else begin
      d_r <= d_nxt;
    end
  end

  assign power_down = pd_now;
  assign pump_grounded = ~d_r.func_word[`FND_PUMP_REL_BIT];
  assign compare_pulse = d_r.cmp_tick;
  assign divide_value = d_r.div_value;
  assign divide_valid = d_r.div_valid;
  assign channel_acquired = d_r.chan_ok;
  assign link.diag_o = d_r.diag_o;
  assign link.diag_oe = d_r.diag_oe;
endmodule : fnd_device
`default_nettype wire

/* hdl/fnd_host.sv */
// Our own choices: the register addresses and the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
`include "fnd_defines.svh"
module fnd_host
  import fnd_pkg::*;
#(
  parameter int INIT_WAIT_CYC = `FND_INIT_WAIT_MS * `FND_US_PER_MS * `FND_ACLK_MHZ
)
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  fnd_link_if.host link
);
  fnd_host_s h_r, h_nxt;
  logic wr_go;
  logic rd_go;
  logic idle;

  // Power-up sequence table: length and word per step
  function automatic logic [28:0] fnd_rom(input logic [3:0] step);
    case (step)
      4'h0: fnd_rom = {`FND_LEN_8, `FND_INIT_0};
      4'h1: fnd_rom = {`FND_LEN_16, `FND_INIT_1};
      4'h2: fnd_rom = {`FND_LEN_16, `FND_INIT_2};
      4'h3: fnd_rom = {`FND_LEN_16, `FND_INIT_3};
      4'h4: fnd_rom = {`FND_LEN_16, `FND_INIT_4};
      4'h5: fnd_rom = {`FND_LEN_24, `FND_INIT_5};
      4'h6: fnd_rom = {`FND_LEN_24, `FND_INIT_6};
      4'h7: fnd_rom = {`FND_LEN_24, `FND_INIT_7};
      4'h8: fnd_rom = {`FND_LEN_16, `FND_INIT_8};
      4'h9: fnd_rom = {`FND_LEN_24, `FND_INIT_9};
      4'hA: fnd_rom = {`FND_LEN_24, `FND_INIT_10};
      4'hB: fnd_rom = {`FND_LEN_16, `FND_INIT_11};
      4'hC: fnd_rom = {`FND_LEN_8, `FND_INIT_12};
      4'hD: fnd_rom = {`FND_LEN_24, `FND_INIT_13};
      default: fnd_rom = 29'h00000000;
    endcase
  endfunction : fnd_rom

  // Config word whose modulus the device cannot take
  function automatic logic fnd_bad(input fnd_word_t w, input logic dith);
    logic [11:0] m;
    m = w[`FND_NUM_HI:`FND_NUM_LO];
    fnd_bad = (w[`FND_SEL_HI:0] == `FND_SEL_CONFIG) &&
              ((m < `FND_MOD_MIN) || (dith && (m < `FND_MOD_MIN_DITHER)));
  endfunction : fnd_bad

  assign idle = (h_r.st == HS_IDLE);
  assign wr_go = s_axi_awvalid & s_axi_wvalid & ~h_r.bvalid;
  assign rd_go = s_axi_arvalid & ~h_r.rvalid;
  assign s_axi_awready = wr_go;
  assign s_axi_wready = wr_go;
  assign s_axi_arready = rd_go;

  always_comb begin
    logic [28:0] rom_next;
    logic launch;
    logic [4:0] l_len;
    fnd_word_t l_word;
    rom_next = fnd_rom(h_r.step + 4'h1);
    launch = 1'h0;
    l_len = h_r.len;
    l_word = h_r.word;
    h_nxt = h_r;
    h_nxt.dg_m = link.diagnostic_output_pin;
    h_nxt.dg_s = h_r.dg_m;

    // Register writes; start commands are ignored while a transfer runs
    if (wr_go) begin
      h_nxt.bvalid = 1'h1;
      h_nxt.bresp = `FND_RESP_OKAY;
      case (s_axi_awaddr)
        `FND_AXI_CTRL: begin
          if (s_axi_wstrb[0] && idle) begin
            if (s_axi_wdata[`FND_CTRL_INIT_BIT]) begin
              h_nxt.init_act = 1'h1;
              h_nxt.init_done = 1'h0;
              h_nxt.step = 4'h0;
              {l_len, l_word} = fnd_rom(4'h0);
              launch = 1'h1;
            end else if (s_axi_wdata[`FND_CTRL_WORD_BIT]) begin
              if (fnd_bad(h_r.word, h_r.dith)) begin
                h_nxt.err = 1'h1;
              end else begin
                launch = 1'h1;
              end
            end
          end
        end
        `FND_AXI_WORD: begin
          for (int i = 0; i < 3; i++) begin
            if (s_axi_wstrb[i]) begin
              h_nxt.word[8*i +: 8] = s_axi_wdata[8*i +: 8];
            end
          end
        end
        `FND_AXI_LEN: begin
          if (s_axi_wstrb[0]) begin
            h_nxt.len = s_axi_wdata[4:0];
          end
        end
        `FND_AXI_STAT: begin
          // Writing status clears the refusal flag
          if (s_axi_wstrb[0]) begin
            h_nxt.err = 1'h0;
          end
        end
        default: begin
          h_nxt.bresp = `FND_RESP_SLVERR;
        end
      endcase
    end else if (h_r.bvalid && s_axi_bready) begin
      h_nxt.bvalid = 1'h0;
    end

    // Register reads
    if (rd_go) begin
      h_nxt.rvalid = 1'h1;
      h_nxt.rresp = `FND_RESP_OKAY;
      h_nxt.rdata = 32'h00000000;
      case (s_axi_araddr)
        `FND_AXI_CTRL: h_nxt.rdata = 32'h00000000;
        `FND_AXI_WORD: h_nxt.rdata = {8'h00, h_r.word};
        `FND_AXI_LEN: h_nxt.rdata = {27'h0000000, h_r.len};
        `FND_AXI_STAT: h_nxt.rdata = {24'h000000, h_r.step, h_r.err, h_r.dg_s, h_r.init_done, ~idle};
        default: h_nxt.rresp = `FND_RESP_SLVERR;
      endcase
    end else if (h_r.rvalid && s_axi_rready) begin
      h_nxt.rvalid = 1'h0;
    end

    // Serial engine
    case (h_r.st)
      HS_IDLE: begin
      end
      HS_SHIFT: begin
        h_nxt.cnt = h_r.cnt + 4'h1;
        if (h_r.cnt == `FND_SCLK_HALF - 4'h1) begin
          h_nxt.cnt = 4'h0;
          h_nxt.sclk = ~h_r.sclk;
          if (h_r.sclk) begin
            h_nxt.sh = {h_r.sh[`FND_WORD_W-2:0], 1'h0};
            h_nxt.bits = h_r.bits - 5'h01;
            if (h_r.bits == 5'h01) begin
              h_nxt.st = HS_LATCH;
              h_nxt.latch = 1'h1;
            end
          end
        end
      end
      HS_LATCH: begin
        h_nxt.cnt = h_r.cnt + 4'h1;
        if (h_r.cnt == `FND_LATCH_CYC - 4'h1) begin
          h_nxt.cnt = 4'h0;
          h_nxt.latch = 1'h0;
          h_nxt.st = HS_GAP;
          if (h_r.cur[`FND_SEL_HI:0] == `FND_SEL_MODE) begin
            h_nxt.dith = (h_r.cur[`FND_MODE_HI:`FND_MODE_LO] == `FND_MODE_DITHER);
          end
        end
      end
      HS_GAP: begin
        // Long gap: the device syncs the strobe on a slow clock before it takes the word
        h_nxt.cnt = h_r.cnt + 4'h1;
        if (h_r.cnt == `FND_GAP_LAST) begin
          h_nxt.cnt = 4'h0;
          h_nxt.st = HS_IDLE;
          if (h_r.init_act) begin
            if (h_r.step == `FND_STEP_LAST) begin
              h_nxt.init_act = 1'h0;
              h_nxt.init_done = 1'h1;
            end else if (h_r.step == `FND_STEP_WAIT) begin
              h_nxt.wcnt = 20'h00000;
              h_nxt.st = HS_WAIT;
            end else begin
              // Table order carries the sequence
              h_nxt.step = h_r.step + 4'h1;
              {l_len, l_word} = rom_next;
              launch = 1'h1;
            end
          end
        end
      end
      HS_WAIT: begin
        h_nxt.wcnt = h_r.wcnt + 20'h00001;
        if (h_r.wcnt == 20'(INIT_WAIT_CYC - 1)) begin
          h_nxt.step = h_r.step + 4'h1;
          {l_len, l_word} = rom_next;
          launch = 1'h1;
        end
      end
      default: begin
        h_nxt.st = HS_IDLE;
      end
    endcase

    // Left-align the word so its top bit leaves first
    if (launch) begin
      h_nxt.st = HS_SHIFT;
      h_nxt.cnt = 4'h0;
      h_nxt.sclk = 1'h0;
      h_nxt.bits = l_len;
      h_nxt.cur = l_word;
      h_nxt.sh = l_word << (`FND_LEN_24 - l_len);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      h_r <= '0;
      h_r.len <= `FND_LEN_24;
    end else begin
      h_r <= h_nxt;
    end
  end

  assign link.link_clk = h_r.sclk;
  assign link.sdata = h_r.sh[`FND_WORD_W-1];
  assign link.word_latch_strobe = h_r.latch;
  assign s_axi_bvalid = h_r.bvalid;
  assign s_axi_bresp = h_r.bresp;
  assign s_axi_rvalid = h_r.rvalid;
  assign s_axi_rresp = h_r.rresp;
  assign s_axi_rdata = h_r.rdata;
endmodule : fnd_host
`default_nettype wire

/* hdl/fnd_sdm.sv */
`timescale 1ns/1ps
`default_nettype none
module fnd_sdm
  import fnd_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic step,
  input wire logic load,
  input wire logic dither_en,
  input wire logic [11:0] fraction_numerator,
  input wire logic [11:0] fraction_modulus,
  input wire logic [11:0] phase_seed,
  output logic signed [3:0] code
);
  fnd_sdm_s s_r, s_nxt;

  // One accumulate-and-wrap stage; inputs stay below twice the modulus
  function automatic logic [12:0] fnd_wrap(input logic [11:0] acc, input logic [12:0] add, input logic [11:0] m);
    logic [13:0] sum;
    sum = {2'h0, acc} + {1'h0, add};
    if (sum >= {2'h0, m}) begin
      fnd_wrap = {1'h1, 12'(sum - {2'h0, m})};
    end else begin
      fnd_wrap = {1'h0, sum[11:0]};
    end
  endfunction : fnd_wrap

  // Three cascaded wrap stages with differentiated carries
  always_comb begin
    logic [12:0] r;
    logic [12:0] feed;
    logic [2:0] c;
    logic [11:0] base;
    logic c2p;
    logic c3p;
    logic c3pp;
    r = 13'h0000;
    c = 3'h0;
    base = 12'h000;
    s_nxt = s_r;
    c2p = load ? 1'h0 : s_r.c2_d;
    c3p = load ? 1'h0 : s_r.c3_d;
    c3pp = load ? 1'h0 : s_r.c3_dd;
    // Dither bit is the counter parity: full 2^21 period
    feed = {1'h0, fraction_numerator} + {12'h000, dither_en & (^s_r.dcnt)};
    if (step) begin
      s_nxt.dcnt = s_r.dcnt + 21'h000001;
      for (int i = 0; i < 3; i++) begin
        // Seed the first stage with the phase word on load
        base = load ? ((i == 0) ? phase_seed : 12'h000) : s_r.acc[i];
        r = fnd_wrap(base, feed, fraction_modulus);
        c[i] = r[12];
        s_nxt.acc[i] = r[11:0];
        feed = {1'h0, r[11:0]};
      end
      s_nxt.c2_d = c[1];
      s_nxt.c3_d = c[2];
      s_nxt.c3_dd = c3p;
      // Third-order noise shaping, repeat length set by the modulus when dither is off
      s_nxt.code = $signed({3'h0, c[0]}) + $signed({3'h0, c[1]}) - $signed({3'h0, c2p})
                 + $signed({3'h0, c[2]}) - $signed({2'h0, c3p, 1'h0}) + $signed({3'h0, c3pp});
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign code = s_r.code;
endmodule : fnd_sdm
`default_nettype wire

/* shared/fnd_defines.svh */
`ifndef FND_DEFINES_SVH
`define FND_DEFINES_SVH

// Serial word and register select
`define FND_WORD_W 24
`define FND_SEL_HI 2
`define FND_SEL_FREQ 3'h0
`define FND_SEL_CONFIG 3'h1
`define FND_SEL_PHASE 3'h2
`define FND_SEL_FUNC 3'h3
`define FND_SEL_TIMER 3'h4
`define FND_SEL_PDOWN 3'h5
`define FND_SEL_MODE 3'h6
`define FND_SEL_TEST 3'h7

// Field positions
`define FND_INT_HI 22
`define FND_INT_LO 15
`define FND_NUM_HI 14
`define FND_NUM_LO 3
`define FND_RDIV_HI 18
`define FND_RDIV_LO 15
`define FND_DBL_BIT 19
`define FND_HALF_BIT 21
`define FND_PD_HI 7
`define FND_PD_LO 3
`define FND_PUMP_REL_BIT 5
`define FND_MODE_HI 15
`define FND_MODE_LO 12
`define FND_MUX_HI 7
`define FND_MUX_LO 4

// Codes and limits
`define FND_MODE_DITHER 4'h3
`define FND_MUX_OFF 4'h0
`define FND_MUX_LOCK 4'h1
`define FND_MUX_NDIV 4'h2
`define FND_MUX_HIGH 4'h3
`define FND_MUX_RCNT 4'h4
`define FND_MUX_LOW 4'h7
`define FND_MUX_RDIV 4'h8
`define FND_MOD_MIN 12'h00D
`define FND_MOD_MIN_DITHER 12'h032
`define FND_PD_RST 8'hF8
`define FND_DITHER_W 21

// Host timing and command map
`define FND_LEN_8 5'h08
`define FND_LEN_16 5'h10
`define FND_LEN_24 5'h18
`define FND_ACLK_MHZ 50
`define FND_US_PER_MS 1000
`define FND_INIT_WAIT_MS 10
`define FND_SCLK_HALF 4'h4
`define FND_LATCH_CYC 4'h8
`define FND_GAP_LAST 4'hF
`define FND_STEP_WAIT 4'h1
`define FND_STEP_LAST 4'hD
`define FND_AXI_CTRL 4'h0
`define FND_AXI_WORD 4'h4
`define FND_AXI_LEN 4'h8
`define FND_AXI_STAT 4'hC
`define FND_CTRL_WORD_BIT 0
`define FND_CTRL_INIT_BIT 1
`define FND_RESP_OKAY 2'h0
`define FND_RESP_SLVERR 2'h2

// Power-up sequence words
`define FND_INIT_0 24'h0000FD
`define FND_INIT_1 24'h00005B
`define FND_INIT_2 24'h000007
`define FND_INIT_3 24'h00000E
`define FND_INIT_4 24'h00900E
`define FND_INIT_5 24'h004464
`define FND_INIT_6 24'h00446C
`define FND_INIT_7 24'h004394
`define FND_INIT_8 24'h0000D2
`define FND_INIT_9 24'h520209
`define FND_INIT_10 24'h480140
`define FND_INIT_11 24'h00007B
`define FND_INIT_12 24'h000005
`define FND_INIT_13 24'h480140

`endif

/* shared/fnd_link_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface fnd_link_if;
  logic link_clk;
  logic sdata;
  logic word_latch_strobe;
  logic diag_o;
  logic diag_oe;
  logic diagnostic_output_pin;

  // Undriven pin reads low, as with a weak pull-down
  assign diagnostic_output_pin = diag_oe & diag_o;

  modport host (
    output link_clk,
    output sdata,
    output word_latch_strobe,
    input diagnostic_output_pin
  );

  modport device (
    input link_clk,
    input sdata,
    input word_latch_strobe,
    output diag_o,
    output diag_oe
  );
endinterface : fnd_link_if
`default_nettype wire

/* shared/fnd_pkg.sv */
`default_nettype none
package fnd_pkg;
`include "fnd_defines.svh"

  typedef logic [`FND_WORD_W-1:0] fnd_word_t;

  typedef enum logic [2:0] {HS_IDLE, HS_SHIFT, HS_LATCH, HS_GAP, HS_WAIT} fnd_hst_e;

  typedef struct packed {
    logic [2:0][11:0] acc;
    logic c2_d;
    logic c3_d;
    logic c3_dd;
    logic [`FND_DITHER_W-1:0] dcnt;
    logic signed [3:0] code;
  } fnd_sdm_s;

  typedef struct packed {
    fnd_word_t shift;
  } fnd_lnk_s;

  typedef struct packed {
    logic lat_m;
    logic lat_s;
    logic lat_d;
    fnd_word_t freq_word;
    fnd_word_t cfg_sh;
    fnd_word_t cfg_act;
    fnd_word_t phase_sh;
    fnd_word_t phase_act;
    logic [15:0] func_word;
    logic [15:0] mode_word;
    logic [7:0] pd_word;
    logic [5:0] ref_acc;
    logic cmp_tick;
    logic step_d;
    logic load_pend;
    logic chan_ok;
    logic [8:0] div_value;
    logic div_valid;
    logic diag_o;
    logic diag_oe;
  } fnd_dev_s;

  typedef struct packed {
    fnd_hst_e st;
    logic sclk;
    logic latch;
    logic [3:0] cnt;
    logic [4:0] bits;
    fnd_word_t sh;
    fnd_word_t cur;
    fnd_word_t word;
    logic [4:0] len;
    logic init_act;
    logic init_done;
    logic [3:0] step;
    logic [19:0] wcnt;
    logic dith;
    logic err;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic dg_m;
    logic dg_s;
  } fnd_host_s;

endpackage : fnd_pkg
`default_nettype wire

/* testbench/fnd_link_properties.sv */
`timescale 1ns/1ps
`default_nettype none
module fnd_link_properties (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic link_clk,
  input wire logic sdata,
  input wire logic word_latch_strobe,
  input wire logic diag_o,
  input wire logic diag_oe,
  input wire logic diagnostic_output_pin
);
  // All link timing is paced by the host clock
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  // Framing of the strobe and the serial clock
  chk_strobe_len: assert property (
    $rose(word_latch_strobe) |-> word_latch_strobe [*8] ##1 !word_latch_strobe) else $error("strobe width");
  chk_strobe_gap: assert property (
    $fell(word_latch_strobe) |-> !word_latch_strobe [*8]) else $error("strobe gap");
  chk_clk_quiet: assert property (
    word_latch_strobe |-> !link_clk) else $error("clock during strobe");
  chk_clk_high: assert property (
    $rose(link_clk) |-> link_clk [*4] ##1 !link_clk) else $error("clock high phase");
  chk_clk_low: assert property (
    $fell(link_clk) |-> !link_clk [*4]) else $error("clock low phase");
  // Data must not move while the device may sample it
  chk_data_hold: assert property (
    link_clk |-> $stable(sdata)) else $error("data moved");
  // Diagnostic pin follows its enable; a disabled pin carries no stale value
  chk_pin_follow: assert property (
    diag_oe |-> diagnostic_output_pin == diag_o) else $error("pin value");
  chk_pin_idle: assert property (
    !diag_oe |-> !diag_o) else $error("pin idle");
endmodule : fnd_link_properties
`default_nettype wire

/* testbench/fractional_n_divider_control_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module fractional_n_divider_control_tb_top;
  logic aclk = 1'h0, rclk = 1'h0, aresetn = 1'h0, s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hF;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rv;
  logic [1:0] s_axi_bresp, s_axi_rresp, rs;
  logic pd, pg, dth, cp, dval, acq;
  logic [8:0] dv;
  int fails = 0, n_tests = 0, i, n = 0, itg = 144, num = 40, dbl, hlf;
  fnd_link_if link ();
  fnd_host #(.INIT_WAIT_CYC(50)) i_fnd_host (.*);
  fnd_device i_fnd_device (.aclk(rclk), .aresetn(aresetn), .link(link), .power_down(pd), .pump_grounded(pg),
    .dither_on(dth), .compare_pulse(cp), .divide_value(dv), .divide_valid(dval), .channel_acquired(acq));
  fnd_link_properties i_fnd_link_properties (.aclk(aclk), .aresetn(aresetn), .link_clk(link.link_clk),
    .sdata(link.sdata), .word_latch_strobe(link.word_latch_strobe), .diag_o(link.diag_o),
    .diag_oe(link.diag_oe), .diagnostic_output_pin(link.diagnostic_output_pin));

  // Reference clock kept out of step with the host clock
  always #10 aclk = ~aclk;
  always #80 rclk = ~rclk;

  // Compare, verdict and bounded waits
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : complete_run
  task automatic tick;
    @(posedge aclk);
    n++;
    if (n > 60000) begin
      fails++;
      complete_run();
    end
  endtask : tick

  // Bus cycles hold every request until its ready edge
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    tick();
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do tick(); while (!(s_axi_awready && s_axi_wready));
    s_axi_awvalid <= 1'h0;
    s_axi_wvalid <= 1'h0;
    do tick(); while (s_axi_bvalid !== 1'h1);
    s_axi_bready <= 1'h0;
  endtask : wr
  task automatic rd(input logic [3:0] a);
    tick();
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do tick(); while (s_axi_arready !== 1'h1);
    s_axi_arvalid <= 1'h0;
    do tick(); while (s_axi_rvalid !== 1'h1);
    rv = s_axi_rdata;
    rs = s_axi_rresp;
    s_axi_rready <= 1'h0;
  endtask : rd
  task automatic send(input logic [31:0] w);
    wr(4'h4, w);
    wr(4'h0, 32'h1);
    do rd(4'hC); while (rv[0] !== 1'h0);
  endtask : send

  // Model: spacing from the divider, mean divide over one repeat length
  task automatic divs(input int den, input int gap);
    int k = 0, s = 0, g = 0, m = 0;
    logic [1:0] q = 2'h0;
    while (k < den + 4) begin
      @(posedge rclk);
      g++;
      m++;
      if (m > 9000) begin
        fails++;
        complete_run();
      end
      if (dval === 1'h1) begin
        if (m > 2) chk(q[1], 1'h1);
        if (k > 1) chk(g, gap);
        chk(32'(dv >= itg - 3 && dv <= itg + 4), 32'h1);
        if (k >= 4) s += dv;
        k++;
        g = 0;
      end
      q = {q[0], cp};
    end
    chk(s, itg * den + num);
  endtask : divs

  // Tests in turn
  initial begin
    i = $urandom(19727);
    repeat (6) @(posedge rclk);
    aresetn <= 1'h1;
    rd(4'h8);
    chk(rv, 32'h18);
    chk({pd, pg, acq}, 3'h6);
    rd(4'h2);
    chk(rs, 2'h2);
    $display("reset test done");
    wr(4'h0, 32'h2);
    do rd(4'hC); while (rv[1] !== 1'h1);
    repeat (4) @(posedge rclk);
    chk({pd, pg, acq, dth}, 4'h2);
    $display("init test done");
    for (i = 0; i < 2; i++) begin
      send(i ? 32'h000076 : 32'h003036);
      send(i ? 32'h020061 : 32'h020141);
      // Let the diagnostic pin settle through the device and host syncs
      repeat (4) @(posedge rclk);
      rd(4'hC);
      chk({dth, rv[3:2]}, i ? 3'h2 : 3'h7);
      wr(4'hC, 32'h0);
    end
    $display("refusal test done");
    send(32'h010209);
    divs(65, 4);
    for (i = 0; i < 3; i++) begin
      itg = 20 + $urandom % 200;
      num = $urandom % 65;
      dbl = $urandom % 2;
      hlf = $urandom % 2;
      send(32'h010209 | dbl << 19 | hlf << 21);
      send(itg << 15 | num << 3);
      repeat (4) @(posedge rclk);
      divs(65, 2 * (1 + hlf) / (1 + dbl));
    end
    $display("channel test done");
    complete_run();
  end
endmodule : fractional_n_divider_control_tb_top
`default_nettype wire
